//--- rtl/uart_serial_port.sv
// Serial port top: Avalon-MM registers, timer clock select, transmitter, receive buffer, interrupt.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_params.svh"
module uart_serial_port (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [4:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_rx_pin,
    input wire logic i_ext_osc_pin,
    input wire logic i_timer_ext_pin,
    output logic o_tx_pin,
    output logic o_irq
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Bit 0 is the receive line, bit 1 the external oscillator, bit 2 the timer input pin.
    // A change is taken only when two stages agree, so a one-cycle glitch never counts.
    logic [2:0] pins_in;
    logic [2:0] sy1_reg;
    logic [2:0] sy2_reg;
    logic [2:0] sy3_reg;
    logic [2:0] filt_reg;
    logic [2:0] filt_prev_reg;

    assign pins_in = {i_timer_ext_pin, i_ext_osc_pin, i_rx_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always_ff @(posedge i_clk_sys or posedge i_reset) begin
                if (i_reset) begin
                    sy1_reg[gi] <= 1'b1;
                    sy2_reg[gi] <= 1'b1;
                    sy3_reg[gi] <= 1'b1;
                    filt_reg[gi] <= 1'b1;
                    filt_prev_reg[gi] <= 1'b1;
                end else begin
                    sy1_reg[gi] <= pins_in[gi];
                    sy2_reg[gi] <= sy1_reg[gi];
                    sy3_reg[gi] <= sy2_reg[gi];
                    if (sy2_reg[gi] == sy3_reg[gi]) begin
                        filt_reg[gi] <= sy3_reg[gi];
                    end
                    filt_prev_reg[gi] <= filt_reg[gi];
                end
            end
        end
    endgenerate

    wire [2:0] pin_rise = filt_reg & ~filt_prev_reg;

    // ****************************************
    // Register bus decode
    // ****************************************
    // Writes finish in the request cycle; reads stall one cycle so read data come from a flop.
    // Only byte lane 0 carries register bits; a write without it is ignored.
    logic rd_done_reg;
    wire rd_first = i_read & ~rd_done_reg;
    wire wr_acc = i_write & i_byteenable[0];
    wire wr_ctrl = wr_acc & (i_address == `OFS_CTRL);
    wire wr_data = wr_acc & (i_address == `OFS_DATA);
    wire wr_tctrl = wr_acc & (i_address == `OFS_TIMER_CTRL);
    wire wr_reload = wr_acc & (i_address == `OFS_RELOAD);
    wire wr_low = wr_acc & (i_address == `OFS_LOW_COUNT);
    wire wr_iclr = wr_acc & (i_address == `OFS_IRQ_CLEAR);
    wire wr_ien = wr_acc & (i_address == `OFS_IRQ_ENABLE);
    wire [7:0] wbyte = i_writedata[7:0];
    assign o_waitrequest = rd_first;

    // ****************************************
    // Register state
    // ****************************************
    // Interrupt status is kept apart from the done flags, so software may clear either one
    // without losing the other.
    uart_pkg::serial_control_t ctrl_reg;
    uart_pkg::timer_clk_sel_t clk_sel_reg;
    logic run_reg;
    logic [7:0] reload_reg;
    logic [7:0] rx_buf_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic irq_reg;
    logic [31:0] readdata_reg;
    logic [7:0] low_count;

    // ****************************************
    // Timer clock selection
    // ****************************************
    logic [1:0] c4_reg;
    logic [3:0] c12_reg;
    logic [1:0] c48_reg;
    logic [2:0] osc_cnt_reg;

    wire tick_div4 = (c4_reg == `DIV4_LAST);
    wire tick_div12 = (c12_reg == `DIV12_LAST);
    wire tick_div48 = tick_div12 & (c48_reg == `DIV48_LAST);
    wire tick_osc8 = pin_rise[1] & (osc_cnt_reg == `OSC_DIV8_LAST);
    // Codes 6 and 7 give no tick at all, which stops the timer without touching run.
    wire timer_tick =
        (clk_sel_reg == uart_pkg::CLK_SYS) ? 1'b1 :
        (clk_sel_reg == uart_pkg::CLK_DIV4) ? tick_div4 :
        (clk_sel_reg == uart_pkg::CLK_DIV12) ? tick_div12 :
        (clk_sel_reg == uart_pkg::CLK_DIV48) ? tick_div48 :
        (clk_sel_reg == uart_pkg::CLK_OSC_DIV8) ? tick_osc8 :
        (clk_sel_reg == uart_pkg::CLK_EXT_PIN) ? pin_rise[2] : 1'b0;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            c4_reg <= 2'h0;
            c12_reg <= 4'h0;
            c48_reg <= 2'h0;
            osc_cnt_reg <= 3'h0;
        end else begin
            c4_reg <= c4_reg + 2'h1;
            c12_reg <= tick_div12 ? 4'h0 : c12_reg + 4'h1;
            if (tick_div12) begin
                c48_reg <= c48_reg + 2'h1;
            end
            if (pin_rise[1]) begin
                osc_cnt_reg <= osc_cnt_reg + 3'h1;
            end
        end
    end

    // ****************************************
    // Baud timers and receiver
    // ****************************************
    logic tx_bit_en;
    logic rx_sample_en;
    logic rx_start;
    logic rx_valid;
    uart_pkg::rx_frame_t rx_frame;

    baud_gen u_baud (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_tick(timer_tick),
        .i_run(run_reg),
        .i_reload(reload_reg),
        .i_low_wr(wr_low),
        .i_low_wdata(wbyte),
        .i_rx_restart(rx_start),
        .o_tx_bit_en(tx_bit_en),
        .o_rx_sample_en(rx_sample_en),
        .o_low_count(low_count)
    );

    uart_rx_shift u_rx (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_rx_level(filt_reg[0]),
        .i_enable(ctrl_reg.receive_enable_bit),
        .i_ninth_mode(ctrl_reg.frame_width_select),
        .i_sample_en(rx_sample_en),
        .o_start_detect(rx_start),
        .o_frame_valid(rx_valid),
        .o_frame(rx_frame)
    );

    // A byte that arrives while the flag is still set is lost; the held byte stays intact.
    wire rx_checked = ctrl_reg.frame_width_select ? rx_frame.ninth : rx_frame.stop;
    wire rx_keep = ctrl_reg.frame_width_select ? rx_frame.ninth : rx_frame.stop;
    wire rx_load = rx_valid & ~ctrl_reg.rx_done_flag
        & (~ctrl_reg.multiproc_check_enable | rx_checked);

    // ****************************************
    // Transmitter
    // ****************************************
    // A write to the data buffer while a frame is still going out is dropped.
    // In 8-bit mode the ninth slot is forced high and serves as the stop bit.
    logic [10:0] tx_shift_reg;
    logic [3:0] tx_count_reg;
    logic tx_busy_reg;
    logic tx_pin_reg;

    wire tx_accept = wr_data & ~tx_busy_reg;
    wire tx_ninth = ctrl_reg.frame_width_select ? ctrl_reg.tx_ninth_bit : 1'b1;
    wire tx_drive = tx_bit_en & tx_busy_reg & (tx_count_reg != 4'h0);
    wire ti_set = tx_drive & (tx_count_reg == 4'h1);

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tx_shift_reg <= 11'h7FF;
            tx_count_reg <= 4'h0;
            tx_busy_reg <= 1'b0;
            tx_pin_reg <= 1'b1;
        end else if (tx_accept) begin
            tx_shift_reg <= {1'b1, tx_ninth, wbyte, 1'b0};
            tx_count_reg <= ctrl_reg.frame_width_select ? `FRAME_LEN_9BIT : `FRAME_LEN_8BIT;
            tx_busy_reg <= 1'b1;
        end else if (tx_drive) begin
            tx_pin_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            tx_count_reg <= tx_count_reg - 4'h1;
        end else if (tx_bit_en & tx_busy_reg) begin
            tx_busy_reg <= 1'b0;
        end
    end

    assign o_tx_pin = tx_pin_reg;

    // ****************************************
    // Register writes, flags and interrupt
    // ****************************************
    // Hardware sets win over a software clear in the same cycle, so no event is lost.
    wire ti_next = ti_set | (wr_ctrl ? wbyte[`CTRL_TI_BIT] : ctrl_reg.tx_done_flag);
    wire ri_next = rx_load | (wr_ctrl ? wbyte[`CTRL_RI_BIT] : ctrl_reg.rx_done_flag);
    wire [1:0] irq_events = {rx_load, ti_set};
    wire [1:0] irq_clr = wr_iclr ? wbyte[1:0] : 2'h0;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg <= '0;
            rx_buf_reg <= `RESET_BYTE;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.frame_width_select <= wbyte[`CTRL_MODE_BIT];
                ctrl_reg.multiproc_check_enable <= wbyte[`CTRL_MCE_BIT];
                ctrl_reg.receive_enable_bit <= wbyte[`CTRL_REN_BIT];
                ctrl_reg.tx_ninth_bit <= wbyte[`CTRL_TB8_BIT];
            end
            if (rx_load) begin
                rx_buf_reg <= rx_frame.data;
                ctrl_reg.rx_ninth_bit <= rx_keep;
            end else if (wr_ctrl) begin
                ctrl_reg.rx_ninth_bit <= wbyte[`CTRL_RB8_BIT];
            end
            ctrl_reg.tx_done_flag <= ti_next;
            ctrl_reg.rx_done_flag <= ri_next;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            run_reg <= 1'b0;
            clk_sel_reg <= uart_pkg::CLK_SYS;
            reload_reg <= `RESET_BYTE;
            irq_status_reg <= 2'h0;
            irq_enable_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            if (wr_tctrl) begin
                run_reg <= wbyte[`TCTRL_RUN_BIT];
                clk_sel_reg <= uart_pkg::timer_clk_sel_t'(wbyte[`TCTRL_SEL_MSB:`TCTRL_SEL_LSB]);
            end
            if (wr_reload) begin
                reload_reg <= wbyte;
            end
            if (wr_ien) begin
                irq_enable_reg <= wbyte[1:0];
            end
            irq_status_reg <= irq_events | (irq_status_reg & ~irq_clr);
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    assign o_irq = irq_reg;

    // ****************************************
    // Read path
    // ****************************************
    // The transmit register has no read path; the data address returns the receive buffer.
    wire [7:0] ctrl_view = {ctrl_reg.frame_width_select, `CTRL_UNUSED_READ,
        ctrl_reg.multiproc_check_enable, ctrl_reg.receive_enable_bit,
        ctrl_reg.tx_ninth_bit, ctrl_reg.rx_ninth_bit,
        ctrl_reg.tx_done_flag, ctrl_reg.rx_done_flag};
    wire [7:0] rd_byte =
        (i_address == `OFS_CTRL) ? ctrl_view :
        (i_address == `OFS_DATA) ? rx_buf_reg :
        (i_address == `OFS_TIMER_CTRL) ? {4'h0, clk_sel_reg, run_reg} :
        (i_address == `OFS_RELOAD) ? reload_reg :
        (i_address == `OFS_LOW_COUNT) ? low_count :
        (i_address == `OFS_IRQ_STATUS) ? {6'h00, irq_status_reg} :
        (i_address == `OFS_IRQ_ENABLE) ? {6'h00, irq_enable_reg} : 8'h00;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rd_done_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            rd_done_reg <= rd_first;
            if (rd_first) begin
                readdata_reg <= {24'h000000, rd_byte};
            end
        end
    end

    assign o_readdata = readdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence s_tx_accept;
        wr_data && !tx_busy_reg;
    endsequence

    sequence s_rx_taken;
        rx_load ##1 ctrl_reg.rx_done_flag;
    endsequence

    a_tx_frame_load: assert property (
        s_tx_accept |=> tx_busy_reg && !tx_shift_reg[0] && tx_count_reg ==
            ($past(ctrl_reg.frame_width_select) ? `FRAME_LEN_9BIT : `FRAME_LEN_8BIT))
        else $error("transmit frame not loaded on data write");
    a_ti_stop_start: assert property (
        ti_set |=> o_tx_pin && tx_busy_reg && tx_count_reg == 4'h0 && ctrl_reg.tx_done_flag)
        else $error("transmit done not set at stop bit start");
    a_flag_sticky: assert property (
        ctrl_reg.rx_done_flag && !wr_ctrl |=> ctrl_reg.rx_done_flag)
        else $error("receive done flag cleared without software");
    a_irq_on_rx: assert property (
        rx_load && irq_enable_reg[`IRQ_RX_BIT] && !wr_ien |-> ##2 o_irq)
        else $error("no interrupt after receive done");
    a_rx_hold_full: assert property (
        rx_valid && ctrl_reg.rx_done_flag |=> $stable(rx_buf_reg))
        else $error("receive buffer overwritten while flag set");
    a_rx_load_data: assert property (
        s_rx_taken |-> rx_buf_reg == $past(rx_frame.data, 1))
        else $error("received byte not stored");
    a_read_rx_buf: assert property (
        rd_first && i_address == `OFS_DATA |=> o_readdata[7:0] == $past(rx_buf_reg)
            && !o_waitrequest)
        else $error("data read did not return receive buffer");
    a_wr_keeps_rx: assert property (
        wr_data && !rx_load |=> rx_buf_reg == $past(rx_buf_reg))
        else $error("data write changed the receive buffer");
    a_timer_stopped: assert property (
        !run_reg && !wr_low |=> low_count == $past(low_count))
        else $error("transmit timer moved while stopped");
    a_ext_tick_only: assert property (
        run_reg && !wr_low && clk_sel_reg == uart_pkg::CLK_EXT_PIN && !pin_rise[2]
            |=> low_count == $past(low_count))
        else $error("timer stepped without an external pin edge");
endmodule : uart_serial_port

//--- common/uart_params.svh
// Constants for the serial port: register offsets, field positions, reset values and counts.
//
// Function
// - Transmit and receive run independently at once, as classic async modes 1 and 3.
// - A finished byte is held in a buffer while the next byte shifts in.
// - One data address: writes go to transmit, reads return the receive buffer only.
// - With interrupts enabled, a hardware set of either done flag raises an interrupt; a software write to the flag does not.
// - Done flags stay set until software clears them explicitly.
// - Baud timing comes from the shared 8-bit auto-reload timer's low count overflows.
// - A hidden receive timer runs with the shared timer and uses the same reload.
// - Transmit and receive timer overflows are each divided by two for baud clocks.
// - A start condition on the receive line forces an immediate receive timer reload.
// - Timer clock: system clock, /4, /12, /48, external oscillator /8, or pin.
// - 8-bit frame: start bit, eight data bits LSB first, stop bit.
// - 9-bit mode sends the ninth bit field, stores the received ninth, ignores stop.
// - Transmit done flag sets at the start of the stop bit time.
// - A received byte loads only if the flag is clear and the multiprocessor check passes.
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH

`define OFS_CTRL 5'h00
`define OFS_DATA 5'h04
`define OFS_TIMER_CTRL 5'h08
`define OFS_RELOAD 5'h0C
`define OFS_LOW_COUNT 5'h10
`define OFS_IRQ_STATUS 5'h14
`define OFS_IRQ_CLEAR 5'h18
`define OFS_IRQ_ENABLE 5'h1C

`define CTRL_MODE_BIT 7
`define CTRL_MCE_BIT 5
`define CTRL_REN_BIT 4
`define CTRL_TB8_BIT 3
`define CTRL_RB8_BIT 2
`define CTRL_TI_BIT 1
`define CTRL_RI_BIT 0
`define CTRL_UNUSED_READ 1'h1

`define TCTRL_RUN_BIT 0
`define TCTRL_SEL_LSB 1
`define TCTRL_SEL_MSB 3

`define IRQ_TX_BIT 0
`define IRQ_RX_BIT 1

`define RESET_BYTE 8'h00
`define PIN_IDLE 3'h7
`define FRAME_LEN_8BIT 4'hA
`define FRAME_LEN_9BIT 4'hB
`define DATA_LAST_8BIT 4'h7
`define DATA_LAST_9BIT 4'h8
`define DIV4_LAST 2'h3
`define DIV12_LAST 4'hB
`define DIV48_LAST 2'h3
`define OSC_DIV8_LAST 3'h7
`define TIMER_TOP 8'hFF

`endif

//--- common/uart_pkg.sv
// Types shared by the serial port modules.
package uart_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_START = 2'h1,
        RX_DATA = 2'h3,
        RX_STOP = 2'h2
    } rx_state_t;

    typedef enum logic [2:0] {
        CLK_SYS = 3'h0,
        CLK_DIV4 = 3'h1,
        CLK_DIV12 = 3'h2,
        CLK_DIV48 = 3'h3,
        CLK_OSC_DIV8 = 3'h4,
        CLK_EXT_PIN = 3'h5
    } timer_clk_sel_t;

    typedef struct packed {
        logic frame_width_select;
        logic multiproc_check_enable;
        logic receive_enable_bit;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } serial_control_t;

    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop;
    } rx_frame_t;
endpackage : uart_pkg

//--- rtl/baud_gen.sv
// Baud timer pair: software-visible transmit timer and hidden receive timer.
`timescale 1ns/1ps
`include "uart_params.svh"
module baud_gen (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic [7:0] i_reload,
    input wire logic i_low_wr,
    input wire logic [7:0] i_low_wdata,
    input wire logic i_rx_restart,
    output logic o_tx_bit_en,
    output logic o_rx_sample_en,
    output logic [7:0] o_low_count
);
    logic [7:0] tx_cnt_reg;
    logic [7:0] rx_cnt_reg;
    logic tx_div_reg;
    logic rx_div_reg;

    wire step = i_tick & i_run;
    wire tx_ovf = step & (tx_cnt_reg == `TIMER_TOP);
    wire rx_ovf = step & (rx_cnt_reg == `TIMER_TOP);

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tx_cnt_reg <= `RESET_BYTE;
            tx_div_reg <= 1'b0;
        end else begin
            if (i_low_wr) begin
                tx_cnt_reg <= i_low_wdata;
            end else if (tx_ovf) begin
                tx_cnt_reg <= i_reload;
            end else if (step) begin
                tx_cnt_reg <= tx_cnt_reg + 8'h01;
            end
            if (tx_ovf) begin
                tx_div_reg <= ~tx_div_reg;
            end
        end
    end

    // The receive copy restarts its divider too, so the first overflow after a start edge
    // lands half a bit later, which puts every later sample near mid-bit.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rx_cnt_reg <= `RESET_BYTE;
            rx_div_reg <= 1'b0;
        end else if (i_rx_restart) begin
            rx_cnt_reg <= i_reload;
            rx_div_reg <= 1'b0;
        end else if (rx_ovf) begin
            rx_cnt_reg <= i_reload;
            rx_div_reg <= ~rx_div_reg;
        end else if (step) begin
            rx_cnt_reg <= rx_cnt_reg + 8'h01;
        end
    end

    assign o_tx_bit_en = tx_ovf & tx_div_reg;
    assign o_rx_sample_en = rx_ovf & ~rx_div_reg;
    assign o_low_count = tx_cnt_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    a_rx_restart_load: assert property (
        i_rx_restart |=> rx_cnt_reg == $past(i_reload) && !rx_div_reg)
        else $error("receive timer not reloaded on start");
    a_tx_half_rate: assert property (
        o_tx_bit_en && !i_low_wr |=> !tx_div_reg && !o_tx_bit_en)
        else $error("transmit bit clock not halved");
endmodule : baud_gen

//--- rtl/uart_rx_shift.sv
// Receive shifter: start detection, bit sampling and frame assembly.
`timescale 1ns/1ps
`include "uart_params.svh"
module uart_rx_shift (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_rx_level,
    input wire logic i_enable,
    input wire logic i_ninth_mode,
    input wire logic i_sample_en,
    output logic o_start_detect,
    output logic o_frame_valid,
    output uart_pkg::rx_frame_t o_frame
);
    uart_pkg::rx_state_t state_reg;
    logic prev_level_reg;
    logic [8:0] shift_reg;
    logic [3:0] cnt_reg;
    logic valid_reg;
    uart_pkg::rx_frame_t frame_reg;

    wire fall = prev_level_reg & ~i_rx_level;
    wire [3:0] data_last = i_ninth_mode ? `DATA_LAST_9BIT : `DATA_LAST_8BIT;
    assign o_start_detect = (state_reg == uart_pkg::RX_IDLE) & i_enable & fall;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= uart_pkg::RX_IDLE;
            prev_level_reg <= 1'b1;
            shift_reg <= 9'h000;
            cnt_reg <= 4'h0;
            valid_reg <= 1'b0;
            frame_reg <= '0;
        end else begin
            prev_level_reg <= i_rx_level;
            valid_reg <= 1'b0;
            case (state_reg)
                uart_pkg::RX_IDLE: begin
                    if (o_start_detect) begin
                        state_reg <= uart_pkg::RX_START;
                        cnt_reg <= 4'h0;
                    end
                end
                uart_pkg::RX_START: begin
                    // A line that is high again at mid start bit was a glitch.
                    if (i_sample_en) begin
                        state_reg <= i_rx_level ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                    end
                end
                uart_pkg::RX_DATA: begin
                    if (i_sample_en) begin
                        shift_reg <= {i_rx_level, shift_reg[8:1]};
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == data_last) begin
                            state_reg <= uart_pkg::RX_STOP;
                        end
                    end
                end
                uart_pkg::RX_STOP: begin
                    if (i_sample_en) begin
                        frame_reg.data <= i_ninth_mode ? shift_reg[7:0] : shift_reg[8:1];
                        frame_reg.ninth <= shift_reg[8];
                        frame_reg.stop <= i_rx_level;
                        valid_reg <= 1'b1;
                        state_reg <= uart_pkg::RX_IDLE;
                    end
                end
                default: begin
                    state_reg <= uart_pkg::RX_IDLE;
                end
            endcase
        end
    end

    assign o_frame_valid = valid_reg;
    assign o_frame = frame_reg;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    a_rx_enable_gate: assert property (
        state_reg == uart_pkg::RX_IDLE && !i_enable |=> state_reg == uart_pkg::RX_IDLE)
        else $error("reception began while disabled");
endmodule : uart_rx_shift

//--- bench/serial_peer.sv
// Far-side serial transceiver model that sends and captures frames.
`timescale 1ns/1ps
module serial_peer #(parameter int BIT_CYC = 32) (
    input wire logic i_clk_sys,
    input wire logic i_line_in,
    output logic o_line_out
);
    initial o_line_out = 1'b1;
    // Start low, data LSB first, optional ninth bit, stop high; idles high afterwards.
    task automatic send(input logic [7:0] b, input logic nine, input logic n9);
        logic [10:0] f;
        f = {1'b1, nine ? n9 : 1'b1, b, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            @(posedge i_clk_sys);
            o_line_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge i_clk_sys);
        end
    endtask : send
    task automatic capture(output logic [7:0] b);
        @(negedge i_line_in);
        repeat (BIT_CYC / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_clk_sys);
            b[i] = i_line_in;
        end
    endtask : capture
endmodule : serial_peer

//--- bench/tb_async_serial_port_with_baud_gen.sv
// Self-checking bench for the serial port.
`timescale 1ns/1ps
module tb_async_serial_port_with_baud_gen;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest, o_tx_pin, o_irq, rx_line;
    logic [7:0] got;
    logic [31:0] q;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_wait = 0;
    logic [1:0] ext_pins = 2'h0;
    logic [15:0] rows [3] = '{16'h5AA5, 16'h00FF, 16'h8001};
    always #50 i_clk_sys = ~i_clk_sys;
    uart_serial_port DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'h1),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rx_pin(rx_line),
        .i_ext_osc_pin(ext_pins[0]), .i_timer_ext_pin(ext_pins[1]), .o_tx_pin(o_tx_pin),
        .o_irq(o_irq));
    serial_peer #(.BIT_CYC(32)) peer (.i_clk_sys(i_clk_sys), .i_line_in(o_tx_pin),
        .o_line_out(rx_line));
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= {24'h0, d};
        @(posedge i_clk_sys);
        n_wait = 0;
        while (o_waitrequest !== 1'b0) begin
            n_wait++;
            @(posedge i_clk_sys);
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus
    task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, q);
        chk("read wait", 32'h1, n_wait);
    endtask : rd
    // Each pulse is long enough on both levels to pass the pin filter.
    task automatic pulse(input int n, input int p);
        repeat (n) begin
            @(posedge i_clk_sys);
            ext_pins[p] <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            ext_pins[p] <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
        end
    endtask : pulse
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rd("ctrl", 5'h00, 8'h40);
        rd("unmapped", 5'h02, 8'h00);
        bus(1'b1, 5'h0C, 8'hF0);
        bus(1'b1, 5'h08, 8'h01);
        bus(1'b1, 5'h1C, 8'h03);
        bus(1'b1, 5'h00, 8'h10);
        foreach (rows[k]) begin
            bus(1'b1, 5'h04, rows[k][15:8]);
            fork
                peer.capture(got);
                peer.send(rows[k][7:0], 1'b0, 1'b0);
            join
            repeat (64) @(posedge i_clk_sys);
            chk("tx byte", {24'h0, rows[k][15:8]}, {24'h0, got});
            rd("ctrl", 5'h00, 8'h57);
            rd("status", 5'h14, 8'h03);
            chk("irq", 32'h1, {31'h0, o_irq});
            rd("data", 5'h04, rows[k][7:0]);
            bus(1'b1, 5'h18, 8'h03);
            bus(1'b1, 5'h00, 8'h10);
            repeat (2) @(posedge i_clk_sys);
            chk("irq", 32'h0, {31'h0, o_irq});
        end
        peer.send(8'h11, 1'b0, 1'b0);
        peer.send(8'h22, 1'b0, 1'b0);
        rd("held", 5'h04, 8'h11);
        bus(1'b1, 5'h00, 8'h00);
        peer.send(8'h33, 1'b0, 1'b0);
        rd("off", 5'h00, 8'h40);
        bus(1'b1, 5'h00, 8'hB0);
        peer.send(8'h3C, 1'b1, 1'b0);
        rd("mce", 5'h00, 8'hF0);
        peer.send(8'hC3, 1'b1, 1'b1);
        rd("mce", 5'h00, 8'hF5);
        rd("data", 5'h04, 8'hC3);
        bus(1'b1, 5'h08, 8'h0B);
        bus(1'b1, 5'h10, 8'h00);
        pulse(5, 1);
        rd("ext pin", 5'h10, 8'h05);
        bus(1'b1, 5'h08, 8'h09);
        pulse(16, 0);
        rd("osc div8", 5'h10, 8'h07);
        end_of_test();
    end
endmodule : tb_async_serial_port_with_baud_gen
